// ==== rtl/cfp_pkg.sv ====
// Purpose: shared constants for the core fetch/execute sequencer
// Assumes: one clock, 100 MHz, each clock edge is one phase of the oscillator
// Notes: data file offsets double as word indices on the register bus
`default_nettype none

package cfp_pkg;

    // -------------------------------------------------------------
    // widths
    // -------------------------------------------------------------
    localparam int PC_W = 13;        // program counter width
    localparam int WORD_W = 14;      // program word width
    localparam int ADDR_W = 9;       // data file address width

    // -------------------------------------------------------------
    // program counter constants
    // -------------------------------------------------------------
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [12:0] SMALL_MASK = 13'h0FFF;   // smaller variant wraps at 4K words

    // -------------------------------------------------------------
    // data file locations within a bank
    // -------------------------------------------------------------
    localparam logic [6:0] LOC_INDIRECT = 7'h00;
    localparam logic [6:0] LOC_PC_LOW = 7'h02;
    localparam logic [6:0] LOC_STATUS = 7'h03;
    localparam logic [6:0] LOC_POINTER = 7'h04;
    localparam logic [6:0] LOC_PC_HIGH = 7'h0A;
    localparam logic [6:0] GPR_BASE = 7'h20;         // general purpose ram start
    localparam logic [6:0] COMMON_BASE = 7'h70;      // shared window into bank zero

    // -------------------------------------------------------------
    // status fields and reset values
    // -------------------------------------------------------------
    localparam int ST_IRP = 7;
    localparam int ST_BANK_HIGH = 6;
    localparam int ST_BANK_LOW = 5;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [4:0] PC_HIGH_RESET = 5'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;

    // -------------------------------------------------------------
    // bus word indices (byte address = index * 4)
    // -------------------------------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h200;    // run, small variant, vector enable
    localparam logic [9:0] IDX_CORE_STATE = 10'h201; // pc and instruction register
    localparam logic [9:0] IDX_WORK = 10'h202;       // working register
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SMALL = 1;
    localparam int CTRL_VEC_EN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // -------------------------------------------------------------
    // instruction encoding
    // -------------------------------------------------------------
    localparam logic [1:0] OP_FILE = 2'h0;           // bit 7 set: work to file, clear: file to work
    localparam logic [1:0] OP_LITERAL = 2'h1;
    localparam logic [1:0] OP_JUMP = 2'h2;
    localparam int DIR_BIT = 7;
    localparam logic [13:0] NOP_WORD = 14'h3000;

    // quadrature phases of one instruction cycle
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} cfp_phase_type;

endpackage : cfp_pkg

`default_nettype wire

// ==== rtl/cfp_core.sv ====
// Purpose: quadrature phase sequencer, two stage fetch/execute pipeline, banked data file
// Assumes: program memory answers within the phase two/three of a fetch cycle
// Notes: registers and the whole data file are reachable over an AHB-Lite slave
//
// Functional notes
// RULE1: oscillator divided into four ordered phases
// RULE2: program counter advances in phase one
// RULE3: program word latched in phase four
// RULE4: instruction cycle is exactly four phases
// RULE5: fetch overlaps execute, one per cycle
// RULE6: program counter changes cost two cycles
// RULE7: taken branch turns prefetch into nop
// RULE8: instruction register loads in phase one
// RULE9: operand read phase two, write phase four
// RULE10: thirteen bit counter, 8K fourteen-bit words
// RULE11: smaller variant wraps above 4K words
// RULE12: reset vector zero, interrupt vector four
// RULE13: two status bits select one bank
// RULE14: core registers mirrored low in each bank
// RULE15: top sixteen bytes shared from bank zero
// RULE16: location zero reaches the pointer target
// RULE17: 96 bytes bank zero, 80 others
// RULE18: unimplemented reads zero, writes ignored
// RULE19: direct address is bank bits plus seven
//
// Added by the designer: the AHB-Lite slave port.
`default_nettype none

module cfp_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // program memory
    output logic [12:0] progAddr,
    input wire logic [13:0] progWord,
    // vector request from interrupt logic
    input wire logic vectorRequest,
    // phase indicators
    output logic phaseOne,
    output logic phaseTwo,
    output logic phaseThree,
    output logic phaseFour,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    cfp_pkg::cfp_phase_type phase;       // current quadrature phase
    cfp_pkg::cfp_phase_type next_phase;
    logic [12:0] pc;                     // program counter
    logic [13:0] fetched;                // prefetched word
    logic [13:0] ir;                     // instruction register
    logic flush;                         // prefetched word must become a nop
    logic [7:0] operand;                 // operand read in phase two
    logic [7:0] work;                    // working register
    logic [7:0] status;                  // bank bits and flags
    logic [7:0] pointer;                 // indirect address pointer
    logic [4:0] pcHigh;                  // high latch of program counter
    logic [2:0] ctrl;                    // run, small variant, vector enable
    logic [7:0] mem [0:511];             // data file storage, only gpr slots used
    logic busPend;                       // data phase in progress
    logic busWrite;                      // pending access is a word write
    logic [11:0] busAddr;                // captured byte address

    // -------------------------------------------------------------
    // helper functions
    // -------------------------------------------------------------
    // RULE16: pointer reached through location zero
    // location zero indirects through the pointer
    function automatic logic [8:0] resolveAddr(input logic [8:0] a, input logic [7:0] st, input logic [7:0] fp);
        logic [8:0] r;
        r = a;
        if (a[6:0] == cfp_pkg::LOC_INDIRECT) begin
            r = {st[cfp_pkg::ST_IRP], fp};
        end
        return r;
    endfunction : resolveAddr

    // common window folds to bank zero, else the full address
    function automatic logic [8:0] physIndex(input logic [8:0] e);
        logic [8:0] r;
        r = e;
        if (e[6:0] >= cfp_pkg::COMMON_BASE) begin
            r = {2'b00, e[6:0]};
        end
        return r;
    endfunction : physIndex

    // general purpose ram slot
    function automatic logic gprHit(input logic [8:0] e);
        return e[6:0] >= cfp_pkg::GPR_BASE;
    endfunction : gprHit

    // RULE11: wrap above 4K words
    // wrap for the smaller variant
    function automatic logic [12:0] wrapPc(input logic [12:0] p, input logic wrapOn);
        return wrapOn ? (p & cfp_pkg::SMALL_MASK) : p;
    endfunction : wrapPc

    // -------------------------------------------------------------
    // decode wires
    // -------------------------------------------------------------
    wire logic run = ctrl[cfp_pkg::CTRL_RUN];
    wire logic smallPart = ctrl[cfp_pkg::CTRL_SMALL];
    wire logic [1:0] irOp = ir[13:12];
    // RULE13: bank from status bits
    wire logic [1:0] bankBits = {status[cfp_pkg::ST_BANK_HIGH], status[cfp_pkg::ST_BANK_LOW]};
    // RULE19: direct address build
    wire logic [8:0] coreDirect = {bankBits, ir[6:0]};
    wire logic [8:0] coreEff = resolveAddr(coreDirect, status, pointer);
    wire logic isPhOne = run && (phase == cfp_pkg::PH_ONE);
    wire logic isPhTwo = run && (phase == cfp_pkg::PH_TWO);
    wire logic isPhFour = run && (phase == cfp_pkg::PH_FOUR);
    wire logic coreWe = isPhFour && (irOp == cfp_pkg::OP_FILE) && ir[cfp_pkg::DIR_BIT];
    wire logic vecTake = isPhFour && ctrl[cfp_pkg::CTRL_VEC_EN] && vectorRequest;
    wire logic jumpTake = isPhFour && !vecTake && (irOp == cfp_pkg::OP_JUMP);
    wire logic [12:0] jumpTarget = wrapPc({pcHigh[4:3], ir[10:0]}, smallPart);
    wire logic [12:0] pcInc = wrapPc(pc + 13'h0001, smallPart);
    wire logic [9:0] busIdx = busAddr[11:2];
    wire logic busFile = !busIdx[9];
    wire logic [8:0] busEff = resolveAddr(busIdx[8:0], status, pointer);
    // bus write waits while the core owns the write port
    wire logic busDoWrite = busPend && busWrite && !coreWe;
    wire logic accept = hsel && htrans[1] && hready;
    wire logic wrEn = coreWe || (busDoWrite && busFile);
    wire logic [8:0] wrAddr = coreWe ? coreEff : busEff;
    wire logic [7:0] wrData = coreWe ? work : hwdata[7:0];
    wire logic wrPcLow = wrEn && (wrAddr[6:0] == cfp_pkg::LOC_PC_LOW);

    // -------------------------------------------------------------
    // read ports
    // -------------------------------------------------------------
    logic [7:0] coreRdData;
    logic [7:0] busFileData;
    logic [31:0] busRdData;

    // one read decode shared by core and bus
    function automatic logic [7:0] readFile(input logic [8:0] e);
        logic [7:0] r;
        r = 8'h00;
        case (e[6:0])
            // RULE14: core registers in every bank
            cfp_pkg::LOC_PC_LOW: r = pc[7:0];
            cfp_pkg::LOC_STATUS: r = status;
            cfp_pkg::LOC_POINTER: r = pointer;
            cfp_pkg::LOC_PC_HIGH: r = {3'b000, pcHigh};
            default: begin
                // RULE18: gaps and pointer-to-zero read zero
                if (gprHit(e)) begin
                    r = mem[physIndex(e)];
                end
            end
        endcase
        return r;
    endfunction : readFile

    // read muxes, evaluated whenever any stored byte changes
    always_comb begin
        coreRdData = readFile(coreEff);
        busFileData = readFile(busEff);
        case (busIdx)
            cfp_pkg::IDX_CONTROL: busRdData = {29'h0000_0000, ctrl};
            cfp_pkg::IDX_CORE_STATE: busRdData = {2'b00, ir, 3'b000, pc};
            cfp_pkg::IDX_WORK: busRdData = {24'h00_0000, work};
            default: busRdData = busFile ? {24'h00_0000, busFileData} : 32'h0000_0000;
        endcase
    end

    // -------------------------------------------------------------
    // phase divider
    // -------------------------------------------------------------
    // RULE1: fixed phase rotation
    // RULE4: four phases per cycle
    always_comb begin
        case (phase)
            cfp_pkg::PH_ONE: next_phase = cfp_pkg::PH_TWO;
            cfp_pkg::PH_TWO: next_phase = cfp_pkg::PH_THREE;
            cfp_pkg::PH_THREE: next_phase = cfp_pkg::PH_FOUR;
            default: next_phase = cfp_pkg::PH_ONE;
        endcase
    end

    // phase register and one-hot indicators, aligned to the phase itself
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase <= cfp_pkg::PH_FOUR;
            phaseOne <= 1'b0;
            phaseTwo <= 1'b0;
            phaseThree <= 1'b0;
            phaseFour <= 1'b1;
        end else begin
            phase <= next_phase;
            phaseOne <= next_phase == cfp_pkg::PH_ONE;
            phaseTwo <= next_phase == cfp_pkg::PH_TWO;
            phaseThree <= next_phase == cfp_pkg::PH_THREE;
            phaseFour <= next_phase == cfp_pkg::PH_FOUR;
        end
    end

    // -------------------------------------------------------------
    // program counter and fetch stage
    // -------------------------------------------------------------
    // pc, prefetch, flush; writes to the low byte take precedence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // RULE12: reset vector
            pc <= cfp_pkg::RESET_VECTOR;
            progAddr <= cfp_pkg::RESET_VECTOR;
            fetched <= cfp_pkg::NOP_WORD;
            flush <= 1'b1;
        end else begin
            // RULE2: advance on phase one
            if (isPhOne) begin
                progAddr <= pc;
                pc <= pcInc;
                flush <= 1'b0;
            end
            // RULE3: latch program word
            if (isPhFour) begin
                fetched <= progWord;
            end
            // RULE12: vector entry
            if (vecTake) begin
                pc <= cfp_pkg::IRQ_VECTOR;
                flush <= 1'b1;
            end
            // RULE6: jump costs a second cycle
            if (jumpTake) begin
                pc <= jumpTarget;
                flush <= 1'b1;
            end
            // RULE10: full counter built from latch and byte
            if (wrPcLow) begin
                pc <= wrapPc({pcHigh, wrData}, smallPart);
                flush <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // execute stage and core registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ir <= cfp_pkg::NOP_WORD;
            operand <= 8'h00;
            work <= 8'h00;
            status <= cfp_pkg::STATUS_RESET;
            pointer <= cfp_pkg::POINTER_RESET;
            pcHigh <= cfp_pkg::PC_HIGH_RESET;
            ctrl <= cfp_pkg::CTRL_RESET;
        end else begin
            // RULE8: load instruction register
            // RULE7: flushed prefetch becomes nop
            if (isPhOne) begin
                ir <= flush ? cfp_pkg::NOP_WORD : fetched;
            end
            // RULE9: operand read
            if (isPhTwo) begin
                operand <= coreRdData;
            end
            // RULE5: execute while next word is fetched
            if (isPhFour && irOp == cfp_pkg::OP_FILE && !ir[cfp_pkg::DIR_BIT]) begin
                work <= operand;
            end
            if (isPhFour && irOp == cfp_pkg::OP_LITERAL) begin
                work <= ir[7:0];
            end
            // vector entry disarms further vectors until software rearms
            if (vecTake) begin
                ctrl[cfp_pkg::CTRL_VEC_EN] <= 1'b0;
            end
            // RULE14: mirrored core registers written from any bank
            if (wrEn && wrAddr[6:0] == cfp_pkg::LOC_STATUS) begin
                status <= wrData;
            end
            if (wrEn && wrAddr[6:0] == cfp_pkg::LOC_POINTER) begin
                pointer <= wrData;
            end
            if (wrEn && wrAddr[6:0] == cfp_pkg::LOC_PC_HIGH) begin
                pcHigh <= wrData[4:0];
            end
            if (busDoWrite && busIdx == cfp_pkg::IDX_CONTROL) begin
                ctrl <= hwdata[2:0];
            end
            if (busDoWrite && busIdx == cfp_pkg::IDX_WORK) begin
                work <= hwdata[7:0];
            end
        end
    end

    // -------------------------------------------------------------
    // data file storage
    // -------------------------------------------------------------
    // RULE9: destination write
    // RULE15: common window lands in bank zero
    // RULE17: only gpr slots are written
    always_ff @(posedge clk_sys) begin
        if (wrEn && gprHit(wrAddr)) begin
            mem[physIndex(wrAddr)] <= wrData;
        end
    end

    // -------------------------------------------------------------
    // ahb-lite slave
    // -------------------------------------------------------------
    // two-cycle data phase so that read data comes from a flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busPend <= 1'b0;
            busWrite <= 1'b0;
            busAddr <= 12'h000;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (accept) begin
                busPend <= 1'b1;
                busWrite <= hwrite && (hsize == cfp_pkg::HSIZE_WORD);
                busAddr <= haddr[11:0];
                hreadyout <= 1'b0;
            end else if (busPend && !(busWrite && coreWe)) begin
                busPend <= 1'b0;
                hreadyout <= 1'b1;
                hrdata <= busWrite ? 32'h0000_0000 : busRdData;
            end
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    phase_order_a: assert property (phaseOne |=> phaseTwo ##1 phaseThree ##1 phaseFour) // RULE1
        else $error("phases out of order");
    cycle_length_a: assert property (phaseOne |-> ##4 phaseOne) // RULE4
        else $error("instruction cycle not four phases");
    pc_advance_a: assert property ((isPhOne && !wrPcLow) |=> pc == $past(pcInc)) // RULE2
        else $error("pc did not advance in phase one");
    fetch_latch_a: assert property (isPhFour |=> fetched == $past(progWord)) // RULE3
        else $error("program word not latched");
    flush_nop_a: assert property ((isPhOne && flush) |=> ir == cfp_pkg::NOP_WORD) // RULE7
        else $error("flushed word executed");
    jump_flush_a: assert property ((jumpTake && !wrPcLow) |=> flush && pc == $past(jumpTarget) // RULE6
        ##4 ir == cfp_pkg::NOP_WORD)
        else $error("jump did not flush");
    vector_load_a: assert property ((vecTake && !wrPcLow) |=> pc == cfp_pkg::IRQ_VECTOR) // RULE12
        else $error("vector not loaded");
    small_wrap_a: assert property ((isPhOne && smallPart && !wrPcLow) |=> pc[12] == 1'b0) // RULE11
        else $error("pc above small range");
    unmapped_zero_a: assert property ((busPend && !busWrite && !coreWe && busFile // RULE18
        && busEff[6:0] > cfp_pkg::LOC_PC_HIGH && busEff[6:0] < cfp_pkg::GPR_BASE) |=> hrdata == 32'h0000_0000)
        else $error("unimplemented location read nonzero");
    bus_wait_a: assert property (accept |=> !hreadyout ##1 hreadyout || busWrite) // RULE9
        else $error("bus answer timing");

endmodule : cfp_core

`default_nettype wire

// ==== tb/cfp_prog_mem.sv ====
// Purpose: program memory model feeding the fetch port of the core
// Assumes: word read registered on every clock, ready long before phase four
// Notes: image is fixed; erased words read all ones, which decodes as a nop
`default_nettype none

module cfp_prog_mem (
    // clock
    input wire logic clk_sys,
    // fetch port
    input wire logic [12:0] progAddr,
    output logic [13:0] progWord
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------
    // storage and image
    // ----------------------------------------------------------
    // full thirteen bit space
    logic [13:0] mem [0:8191]; // fourteen bit words

    // straight code, a jump with a slot that must be flushed, then loops
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 14'h3fff;
        end
        // both halves of the wrap window jump to word four of the page that the high latch selects
        for (int i = 0; i < 16; i++) begin
            mem[13'h0800 + i] = 14'h2004;
            mem[13'h1800 + i] = 14'h2004;
        end
        mem[0] = 14'h1055; // literal to work
        mem[1] = 14'h00a5; // work to file 25
        mem[2] = 14'h2010; // jump
        mem[3] = 14'h1099; // prefetched, must never execute
        mem[4] = 14'h2004; // vector loop
        mem[16] = 14'h00a6; // work to file 26
        mem[17] = 14'h00a7; // work to file 27, bank from status
        mem[18] = 14'h2011; // jump back
    end

    // registered read; the address is stable for the whole cycle
    always_ff @(posedge clk_sys) begin
        progWord <= mem[progAddr];
    end

endmodule : cfp_prog_mem

`default_nettype wire

// ==== tb/tb_core_fetch_pipeline_and_memory_map.sv ====
// Purpose: self-checking bench for the fetch pipeline and data file map
// Assumes: core runs from reset against the fixed program image
// Notes: bus waits last until the slave answers; the watchdog ends any hang
`default_nettype none

module tb_core_fetch_pipeline_and_memory_map;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic vectorRequest = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = cfp_pkg::HSIZE_WORD;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [12:0] progAddr;
    logic [13:0] progWord;
    logic phaseOne, phaseTwo, phaseThree, phaseFour;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [31:0] rd; // last read data
    int miscompares = 0;
    int compares = 0;
    // fetch addresses seen in each phase two, just after the phase-one edge
    localparam logic [12:0] FLOW [6] = '{13'h0000, 13'h0001, 13'h0002, 13'h0003, 13'h0010, 13'h0011};

    always #5 clk_sys = ~clk_sys;

    cfp_core cfp_core_inst (.clk_sys(clk_sys), .rst(rst), .progAddr(progAddr), .progWord(progWord),
        .vectorRequest(vectorRequest), .phaseOne(phaseOne), .phaseTwo(phaseTwo),
        .phaseThree(phaseThree), .phaseFour(phaseFour), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
    cfp_prog_mem cfp_prog_mem_inst (.clk_sys(clk_sys), .progAddr(progAddr), .progWord(progWord));

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task summarize();
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one single word transfer; read data taken at the ready edge
    task bus(input logic wr, input logic [9:0] idx, input logic [31:0] wdat);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, idx, 2'h0};
        hwrite <= wr;
        do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdat;
        do begin @(posedge clk_sys); end while (hreadyout !== 1'b1);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask : bus

    task wr(input logic [9:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task rc(input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask : rc

    // bounded wait for a fetch address, then compare
    task waitAddr(input logic [12:0] a);
        int n;
        n = 0;
        while (progAddr !== a && n < 300) begin @(posedge clk_sys); #1; n++; end
        check(progAddr, a);
    endtask : waitAddr

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    // phases and fetch order
    task flowTest();
        for (int k = 0; k < 24; k++) begin
            @(posedge clk_sys);
            #1;
            check({phaseOne, phaseTwo, phaseThree, phaseFour}, 32'h0000_0008 >> (k % 4));
            if (k % 4 == 1) begin
                check(progAddr, FLOW[k / 4]);
            end
        end
    endtask : flowTest

    // results of the straight code and flushed slot
    task pipeTest();
        rc(10'h003, 8'h18);
        rc(10'h00a, 8'h00);
        rc(10'h200, 8'h01);
        rc(10'h025, 8'h55);
        rc(10'h026, 8'h55);
        rc(10'h202, 8'h55);
    endtask : pipeTest

    task bankTest();
        for (int b = 0; b < 4; b++) begin
            wr(10'h020 + 10'(b * 128), 32'h0000_0011 * (b + 1));
        end
        for (int b = 0; b < 4; b++) begin
            rc(10'h020 + 10'(b * 128), 32'h0000_0011 * (b + 1));
        end
        wr(10'h07f, 8'h5a);
        for (int b = 1; b < 4; b++) begin
            rc(10'h07f + 10'(b * 128), 8'h5a);
        end
        wr(10'h003, 8'h38);
        repeat (20) @(posedge clk_sys);
        rc(10'h0a7, 8'h55);
        rc(10'h183, 8'h38);
        wr(10'h103, 8'h18);
        rc(10'h003, 8'h18);
    endtask : bankTest

    task indirectTest();
        wr(10'h084, 8'h21);
        rc(10'h004, 8'h21);
        wr(10'h021, 8'h66);
        rc(10'h000, 8'h66);
        wr(10'h100, 8'h67);
        rc(10'h021, 8'h67);
        wr(10'h005, 8'hab);
        rc(10'h005, 8'h00);
        rc(10'h01f, 8'h00);
        wr(10'h3ff, 8'hab);
        rc(10'h3ff, 8'h00);
    endtask : indirectTest

    // vector, full range, then small variant wrap
    task vectorTest();
        wr(10'h200, 8'h05);
        vectorRequest <= 1'b1;
        waitAddr(13'h0004);
        @(posedge clk_sys);
        vectorRequest <= 1'b0;
        rc(10'h200, 8'h01);
        wr(10'h00a, 8'h18);
        waitAddr(13'h1804);
        wr(10'h200, 8'h03);
        waitAddr(13'h0804);
    endtask : vectorTest

    // ----------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        flowTest();
        pipeTest();
        bankTest();
        indirectTest();
        vectorTest();
        summarize();
    end

    // the whole run needs well under ten thousand cycles
    initial begin
        #300000;
        miscompares++;
        summarize();
    end

endmodule : tb_core_fetch_pipeline_and_memory_map

`default_nettype wire
